// [src/kwit_map.vh]
/*
 * Address map, field positions, reset values and timing counts of the
 * keyed watchdog / interval timer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef KWIT_MAP_VH
`define KWIT_MAP_VH

// ----------------------------------------------------------------
// bus addresses
// ----------------------------------------------------------------
`define KWIT_ADDR_TCS_RD 32'hffff8610
`define KWIT_ADDR_CNT_RD 32'hffff8611
`define KWIT_ADDR_KEY_WR 32'hffff8610
`define KWIT_ADDR_RCS_WR 32'hffff8612
`define KWIT_ADDR_RCS_RD 32'hffff8613

// ----------------------------------------------------------------
// write keys
// ----------------------------------------------------------------
`define KWIT_KEY_5A 8'h5a
`define KWIT_KEY_A5 8'ha5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define KWIT_BIT_OVF 7
`define KWIT_BIT_MODE 6
`define KWIT_BIT_RUN 5
`define KWIT_BIT_WATCHDOG_OVERFLOW_FLAG 7
`define KWIT_BIT_RESET_ENABLE 6

// ----------------------------------------------------------------
// reset values and fixed read bits
// ----------------------------------------------------------------
`define KWIT_CNT_RESET 8'h00
`define KWIT_TCS_RESET 8'h18
`define KWIT_TCS_FIXED 8'h18
`define KWIT_RCS_RESET 8'h1f
`define KWIT_RCS_FIXED 8'h1f
`define KWIT_CNT_MAX 8'hff

// ----------------------------------------------------------------
// timing counts in system clock cycles
// ----------------------------------------------------------------
`define KWIT_OVF_PULSE_CYC 128
`define KWIT_CHIP_RST_CYC 512

`endif

// [src/kwit_prescaler.v]
/*
 * Free-running system clock divider giving a one-cycle count enable
 * at clk/2 .. clk/8192 chosen by a 3-bit select.
 * Assumes the select is only changed while the counter is stopped.
 */
`timescale 1ns/1ps

module kwit_prescaler #(
    parameter WIDTH = 13
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire [2:0] sel_in,
    output wire tick_out
);

    reg [WIDTH-1:0] div_r;
    reg [WIDTH-1:0] mask;

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= {WIDTH{1'b0}};
        end else begin
            div_r <= div_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // low bits that must all be one for the selected ratio
    always @* begin
        case (sel_in)
            3'h0: mask = 13'h0001;
            3'h1: mask = 13'h003f;
            3'h2: mask = 13'h007f;
            3'h3: mask = 13'h00ff;
            3'h4: mask = 13'h01ff;
            3'h5: mask = 13'h03ff;
            3'h6: mask = 13'h0fff;
            3'h7: mask = 13'h1fff;
            default: mask = 13'h0001;
        endcase
    end

    assign tick_out = ((div_r & mask) == mask);

endmodule // kwit_prescaler

// [src/kwit_stretch.v]
/*
 * One-shot pulse stretcher: a start pulse holds the output high for
 * LEN clock cycles; clear drops it at once.
 * Assumes start and clear come from the same clock domain.
 */
`timescale 1ns/1ps

module kwit_stretch #(
    parameter LEN = 128,
    parameter CW = 10
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire clear_in,
    input wire start_in,
    output wire active_out
);

    reg [CW-1:0] cnt_r;

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= {CW{1'b0}};
        end else if (clear_in) begin
            cnt_r <= {CW{1'b0}};
        end else if (start_in) begin
            cnt_r <= LEN[CW-1:0];
        end else if (cnt_r != {CW{1'b0}}) begin
            cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    assign active_out = (cnt_r != {CW{1'b0}});

endmodule // kwit_stretch

// [src/kwit_timer.v]
/*
 * Keyed watchdog / interval timer: 8-bit counter on a prescaled clock,
 * keyed word writes, byte reads, overflow pulse and internal chip reset.
 * Assumes a single-cycle CPU bus strobe on sys_clk_in, a pin reset that
 * is asynchronous to it, and a standby level from on-chip logic.
 */
`timescale 1ns/1ps
`include "kwit_map.vh"

module kwit_timer (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire ext_reset_pin_n_in,
    input wire standby_in,
    input wire [31:0] bus_addr_in,
    input wire [15:0] bus_wdata_in,
    input wire bus_wr_in,
    input wire bus_rd_in,
    input wire bus_word_in,
    output wire [7:0] bus_rdata_out,
    output wire external_overflow_n_out,
    output wire chip_reset_n_out,
    output wire interval_interrupt_out
);

    // ----------------------------------------------------------------
    // pin reset synchroniser
    // ----------------------------------------------------------------
    reg pin_meta_r;
    reg pin_sync_r;
    wire pin_rst;

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end else begin
            pin_meta_r <= ext_reset_pin_n_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    assign pin_rst = ~pin_sync_r;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [7:0] watchdog_counter_r;
    reg [7:0] watchdog_counter_nxt;
    reg interval_overflow_flag_r;
    reg mode_select_r;
    reg timer_run_r;
    reg [2:0] clock_select_r;
    reg watchdog_overflow_flag_r;
    reg reset_enable_r;
    reg ovf_seen_r;
    reg watchdog_overflow_flag_seen_r;
    reg [7:0] rdata_r;

    wire tick;
    wire overflow;
    wire wd_overflow;
    wire it_overflow;
    wire own_reset;
    wire word_wr;
    wire key_wr;
    wire cnt_load;
    wire tcs_load;
    wire rcs_wr;
    wire watchdog_overflow_flag_clear;
    wire reset_enable_load;
    wire [7:0] tcs_view;
    wire [7:0] rcs_view;
    wire rd_tcs;
    wire rd_cnt;
    wire rd_rcs;

    kwit_prescaler #(
        .WIDTH(13)
    ) u_presc (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .sel_in(clock_select_r),
        .tick_out(tick)
    );

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign word_wr = bus_wr_in & bus_word_in;
    assign key_wr = word_wr & (bus_addr_in == `KWIT_ADDR_KEY_WR);
    assign cnt_load = key_wr & (bus_wdata_in[15:8] == `KWIT_KEY_5A);
    assign tcs_load = key_wr & (bus_wdata_in[15:8] == `KWIT_KEY_A5);
    assign rcs_wr = word_wr & (bus_addr_in == `KWIT_ADDR_RCS_WR);
    assign watchdog_overflow_flag_clear = rcs_wr & (bus_wdata_in == {`KWIT_KEY_A5, 8'h00}) & watchdog_overflow_flag_seen_r;
    assign reset_enable_load = rcs_wr & (bus_wdata_in[15:8] == `KWIT_KEY_5A);

    // ----------------------------------------------------------------
    // overflow detection
    // ----------------------------------------------------------------
    // a counter load in the tick cycle masks the wrap as well as the step; a control write masks the wrap only
    assign overflow = timer_run_r & tick & ~cnt_load & ~tcs_load
        & (watchdog_counter_r == `KWIT_CNT_MAX);
    assign wd_overflow = overflow & mode_select_r & ~pin_rst;
    assign it_overflow = overflow & ~mode_select_r;
    assign own_reset = wd_overflow;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always @* begin
        watchdog_counter_nxt = watchdog_counter_r;
        if (pin_rst || own_reset) begin
            watchdog_counter_nxt = `KWIT_CNT_RESET;
        end else if (!timer_run_r) begin
            // a stopped counter holds 00 even against a keyed load
            watchdog_counter_nxt = `KWIT_CNT_RESET;
        end else if (cnt_load) begin
            watchdog_counter_nxt = bus_wdata_in[7:0];
        end else if (tick) begin
            watchdog_counter_nxt = watchdog_counter_r + 8'h01;
        end
    end

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            watchdog_counter_r <= `KWIT_CNT_RESET;
        end else begin
            watchdog_counter_r <= watchdog_counter_nxt;
        end
    end

    // ----------------------------------------------------------------
    // timer control/status
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            interval_overflow_flag_r <= 1'b0;
            mode_select_r <= 1'b0;
            timer_run_r <= 1'b0;
            clock_select_r <= 3'h0;
            ovf_seen_r <= 1'b0;
        end else if (pin_rst || own_reset) begin
            interval_overflow_flag_r <= 1'b0;
            mode_select_r <= 1'b0;
            timer_run_r <= 1'b0;
            clock_select_r <= 3'h0;
            ovf_seen_r <= 1'b0;
        end else if (standby_in) begin
            interval_overflow_flag_r <= 1'b0;
            mode_select_r <= 1'b0;
            timer_run_r <= 1'b0;
            ovf_seen_r <= 1'b0;
        end else begin
            if (it_overflow) begin
                interval_overflow_flag_r <= 1'b1;
            end else if (tcs_load && ovf_seen_r && !bus_wdata_in[`KWIT_BIT_OVF]) begin
                interval_overflow_flag_r <= 1'b0;
            end
            if (tcs_load) begin
                mode_select_r <= bus_wdata_in[`KWIT_BIT_MODE];
                timer_run_r <= bus_wdata_in[`KWIT_BIT_RUN];
                clock_select_r <= bus_wdata_in[2:0];
                ovf_seen_r <= 1'b0;
            end else if (rd_tcs && interval_overflow_flag_r) begin
                ovf_seen_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // reset control/status
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            watchdog_overflow_flag_r <= 1'b0;
            reset_enable_r <= 1'b0;
            watchdog_overflow_flag_seen_r <= 1'b0;
        end else if (pin_rst || standby_in) begin
            watchdog_overflow_flag_r <= 1'b0;
            reset_enable_r <= 1'b0;
            watchdog_overflow_flag_seen_r <= 1'b0;
        end else begin
            if (wd_overflow) begin
                watchdog_overflow_flag_r <= 1'b1;
            end else if (watchdog_overflow_flag_clear) begin
                watchdog_overflow_flag_r <= 1'b0;
            end
            if (reset_enable_load) begin
                reset_enable_r <= bus_wdata_in[`KWIT_BIT_RESET_ENABLE];
            end
            if (watchdog_overflow_flag_clear) begin
                watchdog_overflow_flag_seen_r <= 1'b0;
            end else if (rd_rcs && watchdog_overflow_flag_r) begin
                watchdog_overflow_flag_seen_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    assign tcs_view = {interval_overflow_flag_r, mode_select_r, timer_run_r, 2'b11,
        clock_select_r} | `KWIT_TCS_FIXED;
    assign rcs_view = {watchdog_overflow_flag_r, reset_enable_r, 6'h00}
        | `KWIT_RCS_FIXED;
    assign rd_tcs = bus_rd_in & ~bus_word_in & (bus_addr_in == `KWIT_ADDR_TCS_RD);
    assign rd_cnt = bus_rd_in & ~bus_word_in & (bus_addr_in == `KWIT_ADDR_CNT_RD);
    assign rd_rcs = bus_rd_in & ~bus_word_in & (bus_addr_in == `KWIT_ADDR_RCS_RD);

    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_r <= 8'h00;
        end else if (rd_tcs) begin
            rdata_r <= tcs_view;
        end else if (rd_cnt) begin
            rdata_r <= watchdog_counter_r;
        end else if (rd_rcs) begin
            rdata_r <= rcs_view;
        end else if (bus_rd_in) begin
            rdata_r <= 8'h00;
        end
    end

    assign bus_rdata_out = rdata_r;

    // ----------------------------------------------------------------
    // overflow pulse and chip reset
    // ----------------------------------------------------------------
    wire ovf_pulse;
    wire chip_rst;

    kwit_stretch #(
        .LEN(`KWIT_OVF_PULSE_CYC),
        .CW(10)
    ) u_ovf_pulse (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(pin_rst),
        .start_in(wd_overflow),
        .active_out(ovf_pulse)
    );

    kwit_stretch #(
        .LEN(`KWIT_CHIP_RST_CYC),
        .CW(10)
    ) u_chip_rst (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(pin_rst),
        .start_in(wd_overflow & reset_enable_r),
        .active_out(chip_rst)
    );

    assign external_overflow_n_out = ~ovf_pulse;
    assign chip_reset_n_out = ~chip_rst;
    assign interval_interrupt_out = interval_overflow_flag_r;

endmodule // kwit_timer

// [sim/kwit_timer_monitor.sv]
/*
 * Port-level assertions and covers for the keyed watchdog / interval timer.
 * Assumes the bind at the foot attaches it to every kwit_timer instance.
 */
`timescale 1ns/1ps
`include "kwit_map.vh"

module kwit_timer_monitor (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire ext_reset_pin_n_in,
    input wire standby_in,
    input wire [31:0] bus_addr_in,
    input wire [15:0] bus_wdata_in,
    input wire bus_wr_in,
    input wire bus_rd_in,
    input wire bus_word_in,
    input wire [7:0] bus_rdata_out,
    input wire external_overflow_n_out,
    input wire chip_reset_n_out,
    input wire interval_interrupt_out
);
    // ----------------------------------------------------------------
    // helper logic
    // ----------------------------------------------------------------
    reg [8:0] ovf_lo_r;
    reg [9:0] rst_lo_r;
    reg [5:0] pin_hist_r;
    wire pin_quiet = &pin_hist_r;
    wire key_hit = bus_wdata_in[15:8] == `KWIT_KEY_5A || bus_wdata_in[15:8] == `KWIT_KEY_A5;
    wire key_wr = bus_wr_in && bus_word_in && bus_addr_in == `KWIT_ADDR_KEY_WR && key_hit;
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ovf_lo_r <= 9'h000;
            rst_lo_r <= 10'h000;
            pin_hist_r <= 6'h3f;
        end else begin
            ovf_lo_r <= external_overflow_n_out ? 9'h000 : ovf_lo_r + 9'h001;
            rst_lo_r <= chip_reset_n_out ? 10'h000 : rst_lo_r + 10'h001;
            pin_hist_r <= {pin_hist_r[4:0], ext_reset_pin_n_in};
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_word_rd;
        bus_rd_in && bus_word_in |=> bus_rdata_out == 8'h00;
    endproperty
    a_word_rd: assert property (p_word_rd) else $error("word read gave data");
    property p_rd_hold;
        !bus_rd_in && pin_quiet |=> $stable(bus_rdata_out);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_ovf_len;
        $rose(external_overflow_n_out) && pin_quiet |-> ovf_lo_r == 9'd128;
    endproperty
    a_ovf_len: assert property (p_ovf_len) else $error("overflow pulse length");
    property p_rst_len;
        $rose(chip_reset_n_out) && pin_quiet |-> rst_lo_r == 10'd512;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("chip reset length");
    property p_rst_with_ovf;
        $fell(chip_reset_n_out) |-> $fell(external_overflow_n_out);
    endproperty
    a_rst_with_ovf: assert property (p_rst_with_ovf) else $error("chip reset alone");
    property p_one_event;
        $rose(interval_interrupt_out) |-> !$fell(external_overflow_n_out);
    endproperty
    a_one_event: assert property (p_one_event) else $error("both events at once");
    property p_irq_clear;
        $fell(interval_interrupt_out) |-> $past(bus_wr_in) || $past(standby_in)
            || !pin_quiet || $fell(external_overflow_n_out);
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("flag dropped alone");
    property p_no_evt_on_wr;
        $fell(external_overflow_n_out) || $rose(interval_interrupt_out) |-> !$past(key_wr);
    endproperty
    a_no_evt_on_wr: assert property (p_no_evt_on_wr) else $error("wrap on write");
    c_wdog: cover property ($fell(external_overflow_n_out));
    c_irq: cover property ($rose(interval_interrupt_out));
    c_chip: cover property ($fell(chip_reset_n_out));
endmodule // kwit_timer_monitor

bind kwit_timer kwit_timer_monitor i_kwit_timer_monitor (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ext_reset_pin_n_in(ext_reset_pin_n_in),
    .standby_in(standby_in), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_word_in(bus_word_in),
    .bus_rdata_out(bus_rdata_out), .external_overflow_n_out(external_overflow_n_out),
    .chip_reset_n_out(chip_reset_n_out), .interval_interrupt_out(interval_interrupt_out)
);

// [sim/kwit_cpu_model.sv]
/*
 * CPU bus master model: one-cycle strobed word or byte accesses.
 * Assumes read data is registered and valid one cycle after the strobe.
 */
`timescale 1ns/1ps

module kwit_cpu_model (
    input wire sys_clk_in,
    input wire [7:0] bus_rdata_in,
    output reg [31:0] bus_addr_out = 32'h00000000,
    output reg [15:0] bus_wdata_out = 16'h0000,
    output reg bus_wr_out = 1'b0,
    output reg bus_rd_out = 1'b0,
    output reg bus_word_out = 1'b0
);
    // ----------------------------------------------------------------
    // one access: key in upper byte, data in lower byte
    // ----------------------------------------------------------------
    task access(input [31:0] a, input [15:0] d, input w, input is_wr, output [7:0] q);
        @(posedge sys_clk_in);
        #1;
        bus_addr_out = a;
        bus_wdata_out = d;
        bus_word_out = w;
        bus_wr_out = is_wr;
        bus_rd_out = !is_wr;
        @(posedge sys_clk_in);
        #1;
        q = bus_rdata_in;
        bus_wr_out = 1'b0;
        bus_rd_out = 1'b0;
        // released bus shows no stale value
        bus_addr_out = ~a;
        bus_wdata_out = ~d;
    endtask
endmodule // kwit_cpu_model

// [sim/testbench.sv]
/*
 * Self-checking bench for the keyed watchdog / interval timer.
 * Assumes the cpu model and the bound monitor are compiled first.
 */
`timescale 1ns/1ps
`include "kwit_map.vh"

module testbench;
    localparam [31:0] AK = `KWIT_ADDR_KEY_WR;
    localparam [31:0] AC = `KWIT_ADDR_CNT_RD;
    localparam [31:0] AW = `KWIT_ADDR_RCS_WR;
    localparam [31:0] AR = `KWIT_ADDR_RCS_RD;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg pin_n = 1'b1;
    reg stby = 1'b0;
    wire [31:0] addr;
    wire [15:0] wdata;
    wire wr, rd, word, ovf_n, chip_n, irq;
    wire [7:0] rdata;
    reg [7:0] q;
    integer n_mismatch = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer n, k, sh;
    always #12.5 clk = ~clk;
    kwit_timer i_kwit_timer (.sys_clk_in(clk), .rst_n_in(rst_n), .ext_reset_pin_n_in(pin_n),
        .standby_in(stby), .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr),
        .bus_rd_in(rd), .bus_word_in(word), .bus_rdata_out(rdata),
        .external_overflow_n_out(ovf_n), .chip_reset_n_out(chip_n), .interval_interrupt_out(irq));
    kwit_cpu_model i_kwit_cpu_model (.sys_clk_in(clk), .bus_rdata_in(rdata), .bus_addr_out(addr),
        .bus_wdata_out(wdata), .bus_wr_out(wr), .bus_rd_out(rd), .bus_word_out(word));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp8(input [7:0] got, input [7:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr16(input [31:0] a, input [15:0] d, input w);
        i_kwit_cpu_model.access(a, d, w, 1'b1, q);
    endtask
    task rd8(input [31:0] a, input [7:0] e);
        i_kwit_cpu_model.access(a, 16'h0000, 1'b0, 1'b0, q);
        cmp8(q, e);
    endtask
    task wait_evt;
        n = 0;
        while (irq !== 1'b1 && ovf_n !== 1'b0 && n < 70000) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        rd8(AK, 8'h18);
        rd8(AC, 8'h00);
        rd8(AR, 8'h1f);
        i_kwit_cpu_model.access(AK, 16'h0000, 1'b1, 1'b0, q);
        cmp8(q, 8'h00);
        $display("reset test done");
        wr16(AK, 16'h5a37, 1'b1);
        rd8(AC, 8'h00);
        wr16(AK, 16'ha538, 1'b0);
        rd8(AK, 8'h18);
        wr16(AK, 16'h1238, 1'b1);
        rd8(AK, 8'h18);
        wr16(AK, 16'ha5ff, 1'b1);
        rd8(AK, 8'h7f);
        wr16(AK, 16'h5af0, 1'b1);
        rd8(AC, 8'hf0);
        wr16(AK, 16'ha518, 1'b1);
        rd8(AC, 8'h00);
        $display("access test done");
        for (k = 0; k < 3; k = k + 1) begin
            sh = (k == 0) ? 1 : k + 5;
            wr16(AK, 16'ha538 | k, 1'b1);
            wait_evt;
            cmp8({7'h0, n >= (255 << sh) && n <= (256 << sh) + 4}, 8'h01);
            cmp8({6'h0, irq, ovf_n}, 8'h03);
            wr16(AK, 16'ha538 | k, 1'b1);
            cmp8({7'h0, irq}, 8'h01);
            rd8(AK, 8'hb8 | k);
            wr16(AK, 16'ha518, 1'b1);
            cmp8({7'h0, irq}, 8'h00);
        end
        $display("interval test done");
        wr16(AW, 16'h5a5f, 1'b1);
        rd8(AR, 8'h5f);
        wr16(AK, 16'ha578, 1'b1);
        wait_evt;
        cmp8({5'h0, irq, ovf_n, chip_n}, 8'h00);
        rd8(AR, 8'hdf);
        rd8(AK, 8'h18);
        wr16(AW, 16'ha500, 1'b0);
        rd8(AR, 8'hdf);
        wr16(AW, 16'ha500, 1'b1);
        rd8(AR, 8'h5f);
        repeat (600) @(posedge clk);
        #1;
        cmp8({6'h0, ovf_n, chip_n}, 8'h03);
        $display("watchdog test done");
        wr16(AK, 16'ha578, 1'b1);
        wait_evt;
        pin_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 pin_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        cmp8({6'h0, ovf_n, chip_n}, 8'h03);
        rd8(AR, 8'h1f);
        wr16(AW, 16'h5a5f, 1'b1);
        wr16(AK, 16'ha53f, 1'b1);
        rd8(AK, 8'h3f);
        @(posedge clk);
        #1 stby = 1'b1;
        @(posedge clk);
        #1 stby = 1'b0;
        rd8(AK, 8'h1f);
        rd8(AR, 8'h1f);
        rd8(AC, 8'h00);
        $display("pin and standby test done");
        complete_run;
    end
endmodule // testbench
